// file: shared/lprtc_pkg.sv
// constants and carrier types for the low-power calendar timer
// assumes one 50 MHz system clock; oscillators arrive as plain pins
package lprtc_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned FD_TIMEOUT_US = 200;
  localparam int unsigned FAIL_CYC_DEF = FD_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned CAL_WIN_W = 20;
  localparam int unsigned WUT_W = 17;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [5:0] HR24_MAX = 6'h23;
  localparam logic [5:0] HR12_NOON = 6'h11;
  localparam logic [5:0] HR12_TOP = 6'h12;
  localparam logic [5:0] HR12_FIRST = 6'h01;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [2:0] WDAY_FIRST = 3'h1;
  localparam logic [5:0] DATE_FIRST = 6'h01;
  localparam logic [4:0] MONTH_MAX = 5'h12;
  localparam logic [4:0] MONTH_FIRST = 5'h01;
  localparam logic [4:0] MONTH_FEB = 5'h02;
  localparam logic [7:0] YEAR_MAX = 8'h99;

  typedef enum logic [1:0] {
    SRC_FAST_EXT, SRC_FAST_RC, SRC_SLOW_EXT, SRC_SLOW_RC
  } lprtc_src_t;

  typedef enum logic [1:0] {FD_OFF, FD_WATCH, FD_FAIL} lprtc_fd_t;

  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] date;
    logic [2:0] wday;
    logic pm;
    logic [5:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } lprtc_cal_t;

  localparam lprtc_cal_t CAL_RST = '{year: 8'h00, month: 5'h01,
    date: 6'h01, wday: 3'h1, pm: 1'b0, hour: 6'h00, min: 8'h00,
    sec: 8'h00};

  typedef struct packed {
    logic msk_date;
    logic msk_hour;
    logic msk_min;
    logic msk_sec;
    logic [5:0] date;
    logic pm;
    logic [5:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } lprtc_alarm_t;
endpackage

// file: verilog/lprtc_tamp.sv
// one tamper input: synchroniser, polarity and sample filter
// assumes sample_i is a one-cycle pulse of the timekeeping clock
`timescale 1ns/100ps
module lprtc_tamp import lprtc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  input wire logic en_i,
  input wire logic high_i,
  input wire logic [1:0] filt_i,
  input wire logic sample_i,
  output logic event_o
);
  logic s1, s2, prev, next_prev, next_event;
  logic [3:0] cnt, next_cnt;
  logic lvl;
  logic [3:0] target;

  always_comb begin
    lvl = high_i ? s2 : ~s2;
    target = 4'h1 << filt_i;
    next_prev = lvl;
    next_cnt = cnt;
    next_event = 1'b0;
    if (!en_i) begin
      next_cnt = '0;
    end else if (filt_i == 2'h0) begin
      next_event = lvl && !prev;
    end else if (sample_i) begin
      // hold count at target so one long pulse gives one event
      if (!lvl) begin
        next_cnt = '0;
      end else if (cnt != target) begin
        next_cnt = cnt + 4'h1;
        next_event = (cnt + 4'h1) == target;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      prev <= 1'b0;
      cnt <= '0;
      event_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      prev <= next_prev;
      cnt <= next_cnt;
      event_o <= next_event;
    end
  end

  AST_TAMP_EDGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    en_i && filt_i == 2'h0 && lvl && !prev |=> event_o)
    else $error("tamper edge not reported");
endmodule

// file: verilog/lprtc_core.sv
// low-power calendar timer: prescalers, calendar, alarm, wakeup timer,
// slow crystal failure detector and three filtered tamper inputs
// assumes config inputs come from clk_i logic; pins and oscillators do not
`timescale 1ns/100ps
module lprtc_core import lprtc_pkg::*; #(
  parameter int unsigned FAIL_CYC = FAIL_CYC_DEF,
  parameter int unsigned APRE_W = 7,
  parameter int unsigned SPRE_W = 15
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic fast_ext_crystal_clk_i,
  input wire logic fast_int_rc_clk_i,
  input wire logic slow_ext_crystal_clk_i,
  input wire logic slow_int_rc_clk_i,
  input wire lprtc_src_t src_sel_i,
  input wire logic fmt12_i,
  input wire logic [APRE_W-1:0] apre_div_i,
  input wire logic [SPRE_W-1:0] spre_div_i,
  input wire logic cal_load_i,
  input wire lprtc_cal_t cal_set_i,
  input wire logic [8:0] calib_minus_i,
  input wire logic shift_req_i,
  input wire logic [14:0] shift_n_i,
  input wire logic alarm_en_i,
  input wire lprtc_alarm_t alarm_i,
  input wire logic alarm_clr_i,
  input wire logic wut_en_i,
  input wire logic [2:0] wut_sel_i,
  input wire logic [15:0] wut_reload_i,
  input wire logic wut_clr_i,
  input wire logic fd_en_i,
  input wire logic fd_auto_i,
  input wire logic fd_irq_en_i,
  input wire logic fd_clr_i,
  input wire logic [2:0] tamper_pin_i,
  input wire logic [2:0] tamper_en_i,
  input wire logic tamper_high_i,
  input wire logic [1:0] tamper_filt_i,
  input wire logic [2:0] tamper_clr_i,
  output lprtc_cal_t cal_o,
  output logic [SPRE_W-1:0] subsec_o,
  output logic shift_busy_o,
  output lprtc_src_t active_src_o,
  output logic alarm_flag_o,
  output logic wut_flag_o,
  output logic fd_flag_o,
  output logic [2:0] tamper_flag_o,
  output logic wake_o
);
  localparam int unsigned FCW = $clog2(FAIL_CYC + 1);

  if (FAIL_CYC < 2 || SPRE_W < 1 || SPRE_W > 16 || APRE_W < 1) begin : g_chk
    $error("lprtc_core: unsupported parameter values");
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [5:0] month_days(input logic [4:0] m,
                                            input logic [7:0] y);
    logic [1:0] r;
    r = {y[4], 1'b0} + y[1:0]; // year mod 4 from BCD tens parity
    if (m == MONTH_FEB) month_days = (r == 2'h0) ? 6'h29 : 6'h28;
    else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
      month_days = 6'h30;
    else month_days = 6'h31;
  endfunction

  // oscillator pins: two flops, third only for edge detect
  logic [3:0] osc_s1, osc_s2, osc_s3;
  logic raw, drop, p, a_tick, s_tick;
  assign raw = osc_s2[active_src_o] && !osc_s3[active_src_o];

  // failure detector on slow crystal edges
  lprtc_fd_t fd_st, next_fd_st;
  logic [FCW-1:0] fd_cnt, next_fd_cnt;
  logic fd_flag_set, next_fd_flag;
  lprtc_src_t next_src;
  logic se_edge;

  always_comb begin
    se_edge = osc_s2[SRC_SLOW_EXT] && !osc_s3[SRC_SLOW_EXT];
    next_fd_st = fd_st;
    next_fd_cnt = se_edge ? '0 : fd_cnt + FCW'(1);
    fd_flag_set = 1'b0;
    unique case (fd_st)
      FD_OFF: begin
        next_fd_cnt = '0;
        if (fd_en_i) next_fd_st = FD_WATCH;
      end
      FD_WATCH: begin
        if (!fd_en_i) next_fd_st = FD_OFF;
        else if (!se_edge && fd_cnt == FCW'(FAIL_CYC - 1)) begin
          next_fd_st = FD_FAIL;
          fd_flag_set = 1'b1;
        end
      end
      FD_FAIL: begin
        next_fd_cnt = '0;
        if (!fd_en_i) next_fd_st = FD_OFF;
      end
    endcase
    next_fd_flag = fd_flag_set || (fd_flag_o && !fd_clr_i);
    next_src = src_sel_i;
    if (fd_st == FD_FAIL && fd_auto_i && src_sel_i == SRC_SLOW_EXT)
      next_src = SRC_SLOW_RC;
  end

  // prescalers, calibration window and shift absorber
  logic [APRE_W-1:0] apre, next_apre;
  logic [SPRE_W-1:0] spre, next_spre;
  logic [CAL_WIN_W-1:0] win, next_win;
  logic [14:0] pend, next_pend;

  always_comb begin
    drop = raw && (win < CAL_WIN_W'(calib_minus_i));
    p = raw && !drop;
    next_win = raw ? win + CAL_WIN_W'(1) : win;
    next_apre = apre;
    next_spre = spre;
    next_pend = pend;
    a_tick = 1'b0;
    s_tick = 1'b0;
    if (p) begin
      if (apre == '0) begin
        next_apre = apre_div_i;
        a_tick = 1'b1;
      end else begin
        next_apre = apre - APRE_W'(1);
      end
    end
    if (a_tick) begin
      if (pend != '0) begin
        next_pend = pend - 15'h1;
      end else if (spre == '0) begin
        next_spre = spre_div_i;
        s_tick = 1'b1;
      end else begin
        next_spre = spre - SPRE_W'(1);
      end
    end
    if (shift_req_i && pend == '0) next_pend = shift_n_i;
    if (cal_load_i) begin
      next_apre = apre_div_i;
      next_spre = spre_div_i;
    end
  end

  // calendar
  lprtc_cal_t next_cal;
  logic day;
  // widened increments, sliced below to the field widths
  logic [7:0] hr_inc, dt_inc, mo_inc;
  assign hr_inc = bcd_inc({2'h0, cal_o.hour});
  assign dt_inc = bcd_inc({2'h0, cal_o.date});
  assign mo_inc = bcd_inc({3'h0, cal_o.month});

  always_comb begin
    next_cal = cal_o;
    day = 1'b0;
    if (cal_load_i) begin
      next_cal = cal_set_i;
    end else if (s_tick) begin
      next_cal.sec = bcd_inc(cal_o.sec);
      if (cal_o.sec == SEC_MAX) begin
        next_cal.sec = '0;
        next_cal.min = bcd_inc(cal_o.min);
        if (cal_o.min == SEC_MAX) begin
          next_cal.min = '0;
          next_cal.hour = hr_inc[5:0];
          if (fmt12_i) begin
            if (cal_o.hour == HR12_TOP) next_cal.hour = HR12_FIRST;
            if (cal_o.hour == HR12_NOON) begin
              next_cal.pm = !cal_o.pm;
              day = cal_o.pm;
            end
          end else if (cal_o.hour == HR24_MAX) begin
            next_cal.hour = '0;
            day = 1'b1;
          end
        end
      end
      if (day) begin
        next_cal.wday = (cal_o.wday == WDAY_MAX) ? WDAY_FIRST
                        : cal_o.wday + 3'h1;
        next_cal.date = dt_inc[5:0];
        if (cal_o.date == month_days(cal_o.month, cal_o.year)) begin
          next_cal.date = DATE_FIRST;
          next_cal.month = mo_inc[4:0];
          if (cal_o.month == MONTH_MAX) begin
            next_cal.month = MONTH_FIRST;
            next_cal.year = (cal_o.year == YEAR_MAX) ? 8'h00
                            : bcd_inc(cal_o.year);
          end
        end
      end
    end
  end

  // alarm, wakeup timer, tamper flags and wake request
  logic cal_upd, hit, w_step;
  logic [3:0] wdiv, next_wdiv, wmask;
  logic [WUT_W-1:0] wcnt, next_wcnt;
  logic wut_on, next_alarm, next_wut;
  logic [2:0] tev, next_tamp;
  logic next_wake;

  always_comb begin
    // masked fields repeat the alarm at the finest masked unit
    hit = alarm_en_i
      && (alarm_i.msk_sec || alarm_i.sec == cal_o.sec)
      && (alarm_i.msk_min || alarm_i.min == cal_o.min)
      && (alarm_i.msk_hour || (alarm_i.hour == cal_o.hour
          && alarm_i.pm == cal_o.pm))
      && (alarm_i.msk_date || alarm_i.date == cal_o.date);
    next_alarm = (cal_upd && hit)
                 || (alarm_flag_o && !alarm_clr_i);
    wmask = 4'hf >> wut_sel_i[1:0];
    next_wdiv = p ? wdiv + 4'h1 : wdiv;
    w_step = wut_sel_i[2] ? s_tick : (p && (wdiv & wmask) == wmask);
    next_wcnt = wcnt;
    next_wut = wut_flag_o && !wut_clr_i;
    if (!wut_on) begin
      next_wcnt = {wut_sel_i[2] & wut_sel_i[1], wut_reload_i};
    end else if (w_step) begin
      if (wcnt == '0) begin
        next_wcnt = {wut_sel_i[2] & wut_sel_i[1], wut_reload_i};
        next_wut = 1'b1;
      end else begin
        next_wcnt = wcnt - WUT_W'(1);
      end
    end
    next_tamp = tev | (tamper_flag_o & ~tamper_clr_i);
    // free-running events end deep sleep, and
    next_wake = alarm_flag_o || wut_flag_o || (|tamper_flag_o)
                || (fd_flag_o && fd_irq_en_i);
  end

  for (genvar i = 0; i < 3; i++) begin : g_tamp
    lprtc_tamp u_tamp (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i(tamper_pin_i[i]),
      .en_i(tamper_en_i[i]),
      .high_i(tamper_high_i),
      .filt_i(tamper_filt_i),
      .sample_i(p),
      .event_o(tev[i])
    );
  end

  assign subsec_o = spre;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_s1 <= '0;
      osc_s2 <= '0;
      osc_s3 <= '0;
      fd_st <= FD_OFF;
      fd_cnt <= '0;
      fd_flag_o <= 1'b0;
      active_src_o <= SRC_SLOW_RC;
      apre <= '0;
      spre <= '0;
      win <= '0;
      pend <= '0;
      shift_busy_o <= 1'b0;
      cal_o <= CAL_RST;
      cal_upd <= 1'b0;
      wdiv <= '0;
      wcnt <= '0;
      wut_on <= 1'b0;
      alarm_flag_o <= 1'b0;
      wut_flag_o <= 1'b0;
      tamper_flag_o <= '0;
      wake_o <= 1'b0;
    end else begin
      osc_s1 <= {slow_int_rc_clk_i, slow_ext_crystal_clk_i,
                 fast_int_rc_clk_i, fast_ext_crystal_clk_i};
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      fd_st <= next_fd_st;
      fd_cnt <= next_fd_cnt;
      fd_flag_o <= next_fd_flag;
      active_src_o <= next_src;
      apre <= next_apre;
      spre <= next_spre;
      win <= next_win;
      pend <= next_pend;
      shift_busy_o <= |next_pend;
      cal_o <= next_cal;
      cal_upd <= s_tick || cal_load_i;
      wdiv <= next_wdiv;
      wcnt <= next_wcnt;
      wut_on <= wut_en_i;
      alarm_flag_o <= next_alarm;
      wut_flag_o <= next_wut;
      tamper_flag_o <= next_tamp;
      wake_o <= next_wake;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_SEC_ROLL: assert property (
    s_tick && !cal_load_i && cal_o.sec == SEC_MAX |=> cal_o.sec == 8'h00)
    else $error("seconds did not wrap");
  AST_HOUR12: assert property (
    s_tick && !cal_load_i && fmt12_i && cal_o.sec == SEC_MAX
    && cal_o.min == SEC_MAX && cal_o.hour == HR12_TOP
    |=> cal_o.hour == HR12_FIRST)
    else $error("12-hour wrap wrong");
  AST_DATE_ROLL: assert property (
    s_tick && !cal_load_i && !fmt12_i && cal_o.sec == SEC_MAX
    && cal_o.min == SEC_MAX && cal_o.hour == HR24_MAX
    && cal_o.date == month_days(cal_o.month, cal_o.year)
    |=> cal_o.date == DATE_FIRST && cal_o.hour == 6'h00)
    else $error("month end rollover wrong");
  AST_SHIFT_ABSORB: assert property (
    a_tick && pend != '0 |-> !s_tick ##1 pend == $past(pend) - 15'h1)
    else $error("shift pulse not absorbed");
  AST_CALIB_DROP: assert property (
    drop |-> !a_tick && !p)
    else $error("calibration drop leaked");
  AST_WUT_FLAG: assert property (
    wut_on && w_step && wcnt == '0 |=> wut_flag_o ##1 wake_o)
    else $error("wakeup flag or wake missing");
  AST_FAIL_DET: assert property (
    fd_st == FD_WATCH && fd_en_i && !se_edge
    && fd_cnt == FCW'(FAIL_CYC - 1) |=> fd_st == FD_FAIL && fd_flag_o)
    else $error("crystal failure not detected");
  AST_FAIL_SWITCH: assert property (
    fd_st == FD_FAIL && fd_auto_i && src_sel_i == SRC_SLOW_EXT
    |=> active_src_o == SRC_SLOW_RC)
    else $error("no switch to slow RC");
  AST_ALARM_SET: assert property (
    cal_upd && hit |=> alarm_flag_o)
    else $error("alarm match not flagged");
  AST_ALARM_STICKY: assert property (
    alarm_flag_o && !alarm_clr_i |=> alarm_flag_o)
    else $error("alarm flag dropped without clear");
endmodule

// file: tb/lprtc_osc_model.sv
// partner model: three free-running oscillator pins, a stoppable slow crystal pin and the tamper pins
// assumes the bench sets tamper levels and may halt the slow crystal
`timescale 1ns/100ps
module lprtc_osc_model #(
  parameter int FE_HALF = 80,
  parameter int FR_HALF = 100,
  parameter int SE_HALF = 160,
  parameter int SR_HALF = 200
) (
  input wire logic slow_stop_i,
  input wire logic [2:0] tamper_lvl_i,
  output logic fast_ext_crystal_clk_o,
  output logic fast_int_rc_clk_o,
  output logic slow_ext_crystal_clk_o,
  output logic slow_int_rc_clk_o,
  output logic [2:0] tamper_pin_o
);
  // odd offsets keep pin edges clear of the system clock edges
  initial begin
    fast_ext_crystal_clk_o = 1'b0;
    #3;
    forever #(FE_HALF) fast_ext_crystal_clk_o = ~fast_ext_crystal_clk_o;
  end
  initial begin
    fast_int_rc_clk_o = 1'b0;
    #3;
    forever #(FR_HALF) fast_int_rc_clk_o = ~fast_int_rc_clk_o;
  end
  // a dead crystal sits low instead of toggling
  initial begin
    slow_ext_crystal_clk_o = 1'b0;
    #7;
    forever begin
      #(SE_HALF);
      slow_ext_crystal_clk_o = slow_stop_i ? 1'b0 :
        ~slow_ext_crystal_clk_o;
    end
  end
  initial begin
    slow_int_rc_clk_o = 1'b0;
    #7;
    forever #(SR_HALF) slow_int_rc_clk_o = ~slow_int_rc_clk_o;
  end
  assign tamper_pin_o = tamper_lvl_i;
endmodule

// file: tb/tb_top.sv
// self-checking bench for the low-power calendar timer
// assumes lprtc_pkg and the oscillator model are compiled first
`timescale 1ns/100ps
module tb_top import lprtc_pkg::*;;
  logic clk_i, resetn_i, fe, fr, se, sr, fmt12, cal_load, shift_req;
  logic alarm_en, alarm_clr, wut_en, wut_clr, fd_en, fd_auto, fd_irq_en;
  logic fd_clr, slow_stop, shift_busy, alarm_flag, wut_flag, fd_flag, wake;
  lprtc_src_t src_sel, active_src;
  logic [6:0] apre;
  logic [14:0] spre, shift_n, subsec;
  lprtc_cal_t cal_set, cal;
  lprtc_alarm_t alarm;
  logic [2:0] wut_sel, tamper_pin, tamper_en, tamper_lvl, tamper_clr;
  logic [2:0] tamper_flag;
  logic [15:0] wut_reload;
  logic [1:0] tamper_filt;
  logic [8:0] calib;
  int err_count, num_checks, cyc;

  lprtc_osc_model osc (.slow_stop_i(slow_stop), .tamper_lvl_i(tamper_lvl),
    .fast_ext_crystal_clk_o(fe), .fast_int_rc_clk_o(fr),
    .slow_ext_crystal_clk_o(se), .slow_int_rc_clk_o(sr),
    .tamper_pin_o(tamper_pin));

  lprtc_core #(.FAIL_CYC(40)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .fast_ext_crystal_clk_i(fe), .fast_int_rc_clk_i(fr),
    .slow_ext_crystal_clk_i(se), .slow_int_rc_clk_i(sr),
    .src_sel_i(src_sel), .fmt12_i(fmt12), .apre_div_i(apre),
    .spre_div_i(spre), .cal_load_i(cal_load), .cal_set_i(cal_set),
    .calib_minus_i(calib), .shift_req_i(shift_req), .shift_n_i(shift_n),
    .alarm_en_i(alarm_en), .alarm_i(alarm), .alarm_clr_i(alarm_clr),
    .wut_en_i(wut_en), .wut_sel_i(wut_sel), .wut_reload_i(wut_reload),
    .wut_clr_i(wut_clr), .fd_en_i(fd_en), .fd_auto_i(fd_auto),
    .fd_irq_en_i(fd_irq_en), .fd_clr_i(fd_clr), .tamper_pin_i(tamper_pin),
    .tamper_en_i(tamper_en), .tamper_high_i(1'b1),
    .tamper_filt_i(tamper_filt), .tamper_clr_i(tamper_clr), .cal_o(cal),
    .subsec_o(subsec), .shift_busy_o(shift_busy), .active_src_o(active_src),
    .alarm_flag_o(alarm_flag), .wut_flag_o(wut_flag), .fd_flag_o(fd_flag),
    .tamper_flag_o(tamper_flag), .wake_o(wake));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // runaway guard, far above the roughly 4500 cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_chg(output int t);
    logic [7:0] s;
    int n;
    s = cal.sec;
    n = 0;
    while (cal.sec === s && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    t = cyc;
  endtask

  function automatic lprtc_cal_t mk(input logic [7:0] y, input logic [4:0] mo,
    input logic [5:0] d, input logic [2:0] w, input logic pm,
    input logic [5:0] h, input logic [7:0] mi, input logic [7:0] s);
    mk = {y, mo, d, w, pm, h, mi, s};
  endfunction

  task automatic load(input lprtc_cal_t c);
    @(posedge clk_i);
    cal_set <= c;
    cal_load <= 1'b1;
    @(posedge clk_i);
    cal_load <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic roll(input logic f, input lprtc_cal_t a, input lprtc_cal_t e);
    int t;
    @(posedge clk_i);
    fmt12 <= f;
    load(a);
    wait_chg(t);
    chk("calendar", e, cal);
  endtask

  task automatic reset_test();
    chk("reset calendar", CAL_RST, cal);
    chk("reset source", SRC_SLOW_RC, active_src);
    chk("reset flags", 48'h0, {alarm_flag, wut_flag, fd_flag, tamper_flag});
  endtask

  // first four pulses after reset fall in the calibration drop block
  task automatic calib_test();
    int t0, t1;
    logic ok;
    t0 = cyc;
    wait_chg(t1);
    ok = (t1 - t0 > 60) && (t1 - t0 < 90);
    chk("calibrated first tick", 48'h1, 48'(ok));
  endtask

  task automatic src_rate();
    int per [4];
    int t0, t1;
    per = '{8, 10, 16, 20};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      src_sel <= lprtc_src_t'(i);
      apre <= 7'h01;
      spre <= 15'h0005;
      load(CAL_RST);
      chk("subsec", 48'h5, subsec);
      chk("source", 48'(i), active_src);
      wait_chg(t0);
      wait_chg(t1);
      chk("second length", 48'(12 * per[i]), 48'(t1 - t0));
    end
    @(posedge clk_i);
    src_sel <= SRC_SLOW_EXT;
    apre <= 7'h00;
  endtask

  task automatic shift_test();
    int t0, t1;
    shift_n <= 15'h0003;
    wait_chg(t0);
    wait_chg(t0);
    @(posedge clk_i);
    shift_req <= 1'b1;
    @(posedge clk_i);
    shift_req <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("shift busy", 48'h1, shift_busy);
    wait_chg(t1);
    chk("shifted second", 48'(9 * 16), 48'(t1 - t0));
    chk("shift idle", 48'h0, shift_busy);
    spre <= 15'h0000;
  endtask

  task automatic alarm_test();
    int t;
    @(posedge clk_i);
    alarm <= '{1'h1, 1'h1, 1'h1, 1'h0, 6'h01, 1'h0, 6'h00, 8'h30, 8'h05};
    alarm_en <= 1'b1;
    load(mk(8'h00, 5'h01, 6'h01, 3'h1, 1'h0, 6'h00, 8'h00, 8'h04));
    chk("alarm early", 48'h0, alarm_flag);
    wait_chg(t);
    repeat (3) @(negedge clk_i);
    chk("alarm", 48'h1, alarm_flag);
    chk("alarm wake", 48'h1, wake);
    wait_chg(t);
    chk("alarm sticky", 48'h1, alarm_flag);
    @(posedge clk_i);
    alarm_clr <= 1'b1;
    alarm.msk_min <= 1'b0;
    alarm.sec <= 8'h07;
    @(posedge clk_i);
    alarm_clr <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("alarm cleared", 48'h0, {alarm_flag, wake});
    wait_chg(t);
    repeat (3) @(negedge clk_i);
    chk("alarm minute mask", 48'h0, alarm_flag);
    alarm_en <= 1'b0;
  endtask

  task automatic wut_test();
    int exp [5];
    int t0, n;
    exp = '{512, 256, 128, 64, 32};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      wut_sel <= 3'(i);
      wut_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
        n = 0;
        while (wut_flag !== 1'b1 && n < 2000) begin
          @(negedge clk_i);
          n++;
        end
        if (k == 0) begin
          t0 = cyc;
          @(posedge clk_i);
          wut_clr <= 1'b1;
          @(posedge clk_i);
          wut_clr <= 1'b0;
          @(negedge clk_i);
        end
      end
      chk("wakeup period", 48'(exp[i]), 48'(cyc - t0));
      // wake follows the flag by one cycle
      @(negedge clk_i);
      chk("wakeup wake", 48'h1, wake);
      @(posedge clk_i);
      wut_en <= 1'b0;
      wut_clr <= 1'b1;
      @(posedge clk_i);
      wut_clr <= 1'b0;
    end
  endtask

  task automatic fd_test();
    int n;
    @(posedge clk_i);
    fd_en <= 1'b1;
    fd_auto <= 1'b1;
    fd_irq_en <= 1'b1;
    repeat (100) @(negedge clk_i);
    chk("fail early", 48'h0, {fd_flag, wake});
    slow_stop <= 1'b1;
    n = 0;
    while (fd_flag !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk("fail delay", 48'h1, 48'(n < 70));
    repeat (2) @(negedge clk_i);
    chk("fallback source", SRC_SLOW_RC, active_src);
    chk("fail wake", 48'h1, wake);
    @(posedge clk_i);
    slow_stop <= 1'b0;
    fd_en <= 1'b0;
    fd_clr <= 1'b1;
    @(posedge clk_i);
    fd_clr <= 1'b0;
  endtask

  task automatic tamper_test();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      tamper_en <= 3'(1 << i);
      tamper_lvl <= 3'h7;
      repeat (8) @(negedge clk_i);
      chk("tamper flag", 48'(1 << i), tamper_flag);
      chk("tamper wake", 48'h1, wake);
      @(posedge clk_i);
      tamper_lvl <= 3'h0;
      tamper_clr <= 3'h7;
      @(posedge clk_i);
      tamper_clr <= 3'h0;
    end
    @(posedge clk_i);
    tamper_filt <= 2'h3;
    tamper_en <= 3'h1;
    tamper_lvl <= 3'h1;
    repeat (100) @(negedge clk_i);
    chk("filtered early", 48'h0, tamper_flag);
    repeat (140) @(negedge clk_i);
    chk("filtered late", 48'h1, tamper_flag);
  endtask

  initial begin
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    resetn_i = 1'b0;
    {cal_load, shift_req, alarm_en, alarm_clr, wut_en, wut_clr} = '0;
    {fd_en, fd_auto, fd_irq_en, fd_clr, slow_stop, fmt12} = '0;
    src_sel = SRC_SLOW_EXT;
    apre = 7'h00;
    spre = 15'h0000;
    shift_n = 15'h0001;
    cal_set = CAL_RST;
    alarm = '0;
    wut_sel = 3'h0;
    wut_reload = 16'h0001;
    {tamper_en, tamper_lvl, tamper_clr} = '0;
    tamper_filt = 2'h0;
    calib = 9'h004;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_test();
    @(posedge clk_i);
    resetn_i <= 1'b1;
    calib_test();
    roll(1'h0, mk(8'h01, 5'h02, 6'h28, 3'h3, 1'h0, 6'h23, 8'h59, 8'h59),
      mk(8'h01, 5'h03, 6'h01, 3'h4, 1'h0, 6'h00, 8'h00, 8'h00));
    roll(1'h0, mk(8'h04, 5'h02, 6'h28, 3'h5, 1'h0, 6'h23, 8'h59, 8'h59),
      mk(8'h04, 5'h02, 6'h29, 3'h6, 1'h0, 6'h00, 8'h00, 8'h00));
    roll(1'h0, mk(8'h04, 5'h04, 6'h30, 3'h1, 1'h0, 6'h23, 8'h59, 8'h59),
      mk(8'h04, 5'h05, 6'h01, 3'h2, 1'h0, 6'h00, 8'h00, 8'h00));
    roll(1'h0, mk(8'h99, 5'h12, 6'h31, 3'h7, 1'h0, 6'h23, 8'h59, 8'h59),
      mk(8'h00, 5'h01, 6'h01, 3'h1, 1'h0, 6'h00, 8'h00, 8'h00));
    roll(1'h0, mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h0, 6'h09, 8'h59, 8'h59),
      mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h0, 6'h10, 8'h00, 8'h00));
    roll(1'h1, mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h0, 6'h11, 8'h59, 8'h59),
      mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h1, 6'h12, 8'h00, 8'h00));
    roll(1'h1, mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h1, 6'h12, 8'h59, 8'h59),
      mk(8'h01, 5'h01, 6'h01, 3'h1, 1'h1, 6'h01, 8'h00, 8'h00));
    roll(1'h1, mk(8'h01, 5'h01, 6'h05, 3'h2, 1'h1, 6'h11, 8'h59, 8'h59),
      mk(8'h01, 5'h01, 6'h06, 3'h3, 1'h0, 6'h12, 8'h00, 8'h00));
    fmt12 <= 1'b0;
    src_rate();
    spre <= 15'h0005;
    shift_test();
    alarm_test();
    wut_test();
    fd_test();
    tamper_test();
    print_verdict();
  end
endmodule
